// file: shared/cbt_defs.svh
// Opcode, field and timing constants for the branch and bit-test executor.
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH
`define CBT_OP_BR_NONNEG 9'h1e9
`define CBT_OP_BR_POS 9'h1e3
`define CBT_OP_BR_PIN 9'h1f5
`define CBT_OP_BR_CARRY 9'h0bd
`define CBT_OP_TEST_MEMORY_FLAG_INDEXED 8'h57
`define CBT_OP_BIT 4'h9
`define CBT_BITSEL_MSB 4'hf
`define CBT_PC_STEP_BR 16'h0002
`define CBT_PC_STEP_BIT 16'h0001
`define CBT_CYC_BR_BASE 4'h2
`define CBT_CYC_TAKEN_ROM 4'h3
`define CBT_CYC_TAKEN_EXT 4'h3
`define CBT_CYC_BIT_BASE 4'h1
`define CBT_PC_RESET 16'h0000
`define CBT_WAIT_W 4
`endif

// file: shared/cbt_pkg.sv
// Types shared by the branch and bit-test executor.
package cbt_pkg;
    typedef enum logic [2:0] {
        CBT_NONE = 3'b000,
        CBT_BR_NONNEG = 3'b001,
        CBT_BR_POS = 3'b010,
        CBT_BR_PIN = 3'b011,
        CBT_BR_CARRY = 3'b100,
        CBT_BIT_DIRECT = 3'b101,
        CBT_BIT_INDEXED = 3'b110
    } cbt_op_t;
    typedef enum logic [1:0] {
        CBT_DEST_RAM = 2'b00,
        CBT_DEST_ROM = 2'b01,
        CBT_DEST_EXT = 2'b10
    } cbt_dest_t;
    typedef enum logic [1:0] {
        CBT_IDLE = 2'b00,
        CBT_BUSY = 2'b01,
        CBT_DONE = 2'b10
    } cbt_state_t;
endpackage

// file: logic/cbt_aux_update.sv
// Indirect-addressing update of the current auxiliary register and pointer.
`timescale 1ns/100ps
`include "cbt_defs.svh"
module cbt_aux_update (
    input wire logic [6:0] ind_field,
    input wire logic [2:0] aux_pointer,
    input wire logic [15:0] aux_cur,
    input wire logic [15:0] aux_zero,
    output logic [15:0] aux_new,
    output logic [2:0] pointer_new,
    output logic aux_write
);
    // Field: bit 6..4 step code, bit 3 new-pointer enable, bits 2..0 new pointer.
    always_comb begin
        aux_new = aux_cur;
        aux_write = 1'b1;
        case (ind_field[6:4])
            3'b000: aux_write = 1'b0;
            3'b001: aux_new = aux_cur - 16'h0001;
            3'b010: aux_new = aux_cur + 16'h0001;
            3'b101: aux_new = aux_cur - aux_zero;
            3'b110: aux_new = aux_cur + aux_zero;
            default: aux_write = 1'b0;
        endcase
        pointer_new = ind_field[3] ? ind_field[2:0] : aux_pointer;
    end
endmodule

// file: logic/cbt_exec.sv
// Executor for conditional branches and bit-test instructions.
`timescale 1ns/100ps
`include "cbt_defs.svh"
// Operation
// RULE1 - Nonnegative branch taken when sum >= 0
// RULE2 - Positive branch taken only when sum > 0
// RULE3 - Pin branch taken when input pin low
// RULE4 - Carry branch taken when carry flag is 1
// RULE5 - Not taken advances counter by two
// RULE6 - Auxiliary update applied regardless of outcome
// RULE7 - No encoded update leaves auxiliaries unchanged
// RULE8 - Taken: 2 RAM, 3 ROM, 3+p external
// RULE9 - Not taken: 2, or 2+2p external fetch
// RULE10 - Branches refused under single-instruction repeat
// RULE11 - Direct bit test copies bit into flag
// RULE12 - Opcode selector picks bit 15 minus code
// RULE13 - Indexed selector from operand bits 3..0
// RULE14 - Bit test 1 cycle plus d, p; with external data the code takes 2+d cycles (plus p for an external fetch)
// RULE15 - Wait states p, d stretch the accesses
// RULE16 - Bit test advances counter by one
module cbt_exec #(
    parameter int WAIT_W = `CBT_WAIT_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_target,
    input wire logic fetch_external,
    input wire logic [1:0] dest_kind,
    input wire logic data_external,
    input wire logic repeat_active,
    input wire logic [WAIT_W-1:0] prog_wait,
    input wire logic [WAIT_W-1:0] data_wait,
    input wire logic [31:0] sum_register,
    input wire logic carry_flag,
    input wire logic branch_input_pin_n,
    input wire logic [15:0] mult_operand,
    input wire logic [15:0] data_word,
    input wire logic [15:0] aux_register_in,
    input wire logic [15:0] aux_zero_in,
    output logic [15:0] program_counter,
    output logic [2:0] aux_pointer,
    output logic [15:0] aux_register_out,
    output logic aux_write,
    output logic [2:0] aux_write_sel,
    output logic test_control_flag,
    output logic busy,
    output logic done,
    output logic repeat_refused
);
    import cbt_pkg::*;
    localparam int CW = 8;
    logic pin_meta_ff;
    logic pin_sync_ff;
    cbt_state_t state_ff;
    logic [CW-1:0] count_ff;
    logic [15:0] nxt_pc;
    logic [CW-1:0] nxt_cycles;
    logic nxt_taken;
    cbt_op_t op;
    logic [3:0] bit_code;
    logic [15:0] aux_new;
    logic [2:0] pointer_new;
    logic aux_wr_req;
    logic [15:0] pc_hold_ff;
    logic [CW-1:0] pw;
    logic [CW-1:0] dw;

    assign pw = CW'(prog_wait);
    assign dw = CW'(data_wait);

    // The pin is asynchronous to the core, so it is synchronised before use.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= branch_input_pin_n;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    always_comb begin
        op = CBT_NONE;
        if (instr_word[15:7] == `CBT_OP_BR_NONNEG) op = CBT_BR_NONNEG;
        else if (instr_word[15:7] == `CBT_OP_BR_POS) op = CBT_BR_POS;
        else if (instr_word[15:7] == `CBT_OP_BR_PIN) op = CBT_BR_PIN;
        else if (instr_word[15:7] == `CBT_OP_BR_CARRY) op = CBT_BR_CARRY;
        else if (instr_word[15:8] == `CBT_OP_TEST_MEMORY_FLAG_INDEXED) op = CBT_BIT_INDEXED;
        else if (instr_word[15:12] == `CBT_OP_BIT) op = CBT_BIT_DIRECT;
    end

    cbt_aux_update u_aux (
        .ind_field(instr_word[6:0]),
        .aux_pointer(aux_pointer),
        .aux_cur(aux_register_in),
        .aux_zero(aux_zero_in),
        .aux_new(aux_new),
        .pointer_new(pointer_new),
        .aux_write(aux_wr_req)
    );

    // Condition, next counter and cycle count for the decoded instruction.
    always_comb begin
        nxt_taken = 1'b0;
        case (op)
            CBT_BR_NONNEG: nxt_taken = ~sum_register[31]; // see RULE1
            CBT_BR_POS: nxt_taken = ~sum_register[31] && (sum_register != 32'h0000_0000); // see RULE2
            CBT_BR_PIN: nxt_taken = ~pin_sync_ff; // see RULE3
            CBT_BR_CARRY: nxt_taken = carry_flag; // see RULE4
            default: nxt_taken = 1'b0;
        endcase
        bit_code = (op == CBT_BIT_INDEXED) ? mult_operand[3:0] : instr_word[11:8]; // see RULE12 RULE13
        nxt_pc = program_counter + `CBT_PC_STEP_BIT; // see RULE16
        nxt_cycles = CW'(`CBT_CYC_BIT_BASE);
        if (op == CBT_BIT_DIRECT || op == CBT_BIT_INDEXED) begin
            // An external data access adds one cycle plus its wait states, an external fetch adds its wait states. see RULE14 RULE15
            nxt_cycles = CW'(`CBT_CYC_BIT_BASE) + (data_external ? (8'h01 + dw) : 8'h00)
                + (fetch_external ? pw : 8'h00);
        end else if (nxt_taken) begin
            nxt_pc = instr_target;
            if (fetch_external) begin
                // Both words fetched externally, plus the destination fetch if the destination is external.
                case (dest_kind)
                    CBT_DEST_RAM: nxt_cycles = CW'(`CBT_CYC_BR_BASE) + pw + pw; // see RULE8 RULE15
                    CBT_DEST_ROM: nxt_cycles = CW'(`CBT_CYC_TAKEN_ROM) + pw + pw;
                    default: nxt_cycles = CW'(`CBT_CYC_TAKEN_EXT) + pw + pw + pw;
                endcase
            end else begin
                case (dest_kind)
                    CBT_DEST_RAM: nxt_cycles = CW'(`CBT_CYC_BR_BASE); // see RULE8
                    CBT_DEST_ROM: nxt_cycles = CW'(`CBT_CYC_TAKEN_ROM);
                    default: nxt_cycles = CW'(`CBT_CYC_TAKEN_EXT) + pw;
                endcase
            end
        end else begin
            nxt_pc = program_counter + `CBT_PC_STEP_BR; // see RULE5
            nxt_cycles = CW'(`CBT_CYC_BR_BASE) + (fetch_external ? (pw + pw) : 8'h00); // see RULE9
        end
    end

    logic start;
    logic is_branch;
    assign is_branch = (op == CBT_BR_NONNEG) || (op == CBT_BR_POS) || (op == CBT_BR_PIN) || (op == CBT_BR_CARRY);
    // A repeated branch would re-fetch a two-word opcode, so it is refused outright.
    assign start = instr_valid && (state_ff == CBT_IDLE) && (op != CBT_NONE)
        && !(is_branch && repeat_active); // see RULE10

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= CBT_IDLE;
            count_ff <= '0;
        end else begin
            case (state_ff)
                CBT_IDLE: begin
                    if (start) begin
                        count_ff <= nxt_cycles - 8'h01;
                        state_ff <= (nxt_cycles == 8'h01) ? CBT_DONE : CBT_BUSY;
                    end
                end
                CBT_BUSY: begin
                    count_ff <= count_ff - 8'h01;
                    if (count_ff == 8'h01) state_ff <= CBT_DONE;
                end
                CBT_DONE: state_ff <= CBT_IDLE;
                default: state_ff <= CBT_IDLE;
            endcase
        end
    end

    // The next counter is latched on acceptance and written to program_counter on the edge that ends the done cycle; done marks the last cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pc_hold_ff <= `CBT_PC_RESET;
        end else if (start) begin
            pc_hold_ff <= nxt_pc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            program_counter <= `CBT_PC_RESET;
        end else if (state_ff != CBT_IDLE && (state_ff == CBT_DONE)) begin
            program_counter <= pc_hold_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aux_pointer <= 3'h0;
            aux_register_out <= 16'h0000;
            aux_write <= 1'b0;
            aux_write_sel <= 3'h0;
        end else begin
            aux_write <= 1'b0;
            if (start && (is_branch || instr_word[7])) begin
                // Applied on every branch whatever the outcome. see RULE6 RULE7
                aux_write <= aux_wr_req;
                aux_write_sel <= aux_pointer;
                aux_register_out <= aux_new;
                aux_pointer <= pointer_new;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            test_control_flag <= 1'b0;
        end else if (start && (op == CBT_BIT_DIRECT || op == CBT_BIT_INDEXED)) begin
            test_control_flag <= data_word[`CBT_BITSEL_MSB - bit_code]; // see RULE11 RULE12 RULE13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            repeat_refused <= 1'b0;
        end else begin
            // A one-cycle instruction never reports busy, only its done pulse.
            busy <= (start && nxt_cycles != 8'h01) || (state_ff == CBT_BUSY && count_ff != 8'h01);
            done <= (start && nxt_cycles == 8'h01) || (state_ff == CBT_BUSY && count_ff == 8'h01);
            repeat_refused <= instr_valid && (state_ff == CBT_IDLE) && is_branch && repeat_active; // see RULE10
        end
    end
endmodule

// file: bench/cbt_exec_props.sv
// Port-level checker for the branch and bit-test executor.
`timescale 1ns/100ps
`include "cbt_defs.svh"
module cbt_exec_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_target,
    input wire logic fetch_external,
    input wire logic [1:0] dest_kind,
    input wire logic data_external,
    input wire logic repeat_active,
    input wire logic carry_flag,
    input wire logic [15:0] mult_operand,
    input wire logic [15:0] data_word,
    input wire logic [15:0] program_counter,
    input wire logic aux_write,
    input wire logic test_control_flag,
    input wire logic busy,
    input wire logic done,
    input wire logic repeat_refused
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic acc, dbit, ibit, isbr, dsel, isel, lat_bit_ff;
    logic [15:0] lat_tgt_ff;
    assign acc = instr_valid && !busy && !done;
    assign dbit = instr_word[15:12] == `CBT_OP_BIT;
    assign ibit = instr_word[15:8] == `CBT_OP_TEST_MEMORY_FLAG_INDEXED;
    assign isbr = instr_word[15:7] inside {`CBT_OP_BR_NONNEG, `CBT_OP_BR_POS, `CBT_OP_BR_PIN, `CBT_OP_BR_CARRY};
    // The tested bit is 15 minus the code, which is the inverted code.
    assign dsel = data_word[~instr_word[11:8]];
    assign isel = data_word[~mult_operand[3:0]];
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lat_bit_ff <= 1'b0;
            lat_tgt_ff <= 16'h0000;
        end else if (acc) begin
            lat_bit_ff <= dbit || ibit;
            lat_tgt_ff <= instr_target;
        end
    end
    pc_bit_a: assert property (done && lat_bit_ff |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("bit test counter step");
    pc_branch_a: assert property (done && !lat_bit_ff |=> program_counter == $past(program_counter) + 16'h0002 ||
        program_counter == lat_tgt_ff) else $error("branch counter step");
    bit_time_a: assert property (acc && (dbit || ibit) && !fetch_external && !data_external |=> done && !busy)
        else $error("bit test time");
    ram_time_a: assert property (acc && isbr && !repeat_active && !fetch_external && dest_kind == 2'b00
        |=> busy && !done ##1 done && !busy) else $error("branch ram time");
    rom_time_a: assert property (acc && instr_word[15:7] == `CBT_OP_BR_CARRY && carry_flag && !repeat_active &&
        !fetch_external && dest_kind == 2'b01 |=> busy [*2] ##1 done) else $error("branch rom time");
    repeat_refuse_a: assert property (acc && isbr && repeat_active |=> repeat_refused && !busy && !done)
        else $error("repeat not refused");
    tc_direct_a: assert property (acc && dbit |=> test_control_flag == $past(dsel))
        else $error("direct bit wrong");
    tc_index_a: assert property (acc && ibit |=> test_control_flag == $past(isel))
        else $error("indexed bit wrong");
    aux_hold_a: assert property (acc && isbr && instr_word[6:0] == 7'h00 |=> !aux_write)
        else $error("aux written");
endmodule
bind cbt_exec cbt_exec_props u_props (.sys_clk, .rst_n, .instr_valid, .instr_word, .instr_target, .fetch_external,
    .dest_kind, .data_external, .repeat_active, .carry_flag, .mult_operand, .data_word, .program_counter, .aux_write,
    .test_control_flag, .busy, .done, .repeat_refused);

// file: bench/cbt_mem_model.sv
// Behavioural data memory words and branch input pin facing the executor.
`timescale 1ns/100ps
module cbt_mem_model (
    input wire logic word_sel,
    input wire logic pin_low_req,
    output logic [15:0] data_word,
    output logic branch_input_pin_n
);
    assign data_word = word_sel ? 16'h8001 : 16'h5a3c;
    // The pin has a pull-up, so an idle peripheral reads high.
    assign branch_input_pin_n = pin_low_req ? 1'b0 : 1'b1;
endmodule

// file: bench/cbt_exec_tb.sv
// Self-checking bench for the branch and bit-test executor.
`timescale 1ns/100ps
`include "cbt_defs.svh"
module cbt_exec_tb;
    localparam logic [15:0] PAT0 = 16'h5a3c;
    localparam logic [15:0] PAT1 = 16'h8001;
    logic sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, fetch_external = 1'b0, data_external = 1'b0;
    logic repeat_active = 1'b0, carry_flag = 1'b0, pin_low_req = 1'b0, word_sel = 1'b0;
    logic [15:0] instr_word = 16'h0000, instr_target = 16'h0000, mult_operand = 16'h0000;
    logic [15:0] aux_register_in = 16'h1234, aux_zero_in = 16'h0010, pc_exp = 16'h0000;
    logic [1:0] dest_kind = 2'b00;
    logic [3:0] prog_wait = 4'h0, data_wait = 4'h0;
    logic [31:0] sum_register = 32'h0;
    logic [15:0] data_word, program_counter, aux_register_out, cap_aux;
    logic [2:0] aux_pointer, aux_write_sel, cap_ptr, cap_sel;
    logic branch_input_pin_n, aux_write, test_control_flag, busy, done, repeat_refused, cap_wr, cap_tc;
    int err_count = 0, checks_done = 0, cap_n, cycles = 0, i;
    cbt_exec uut (.sys_clk, .rst_n, .instr_valid, .instr_word, .instr_target, .fetch_external, .dest_kind,
        .data_external, .repeat_active, .prog_wait, .data_wait, .sum_register, .carry_flag, .branch_input_pin_n,
        .mult_operand, .data_word, .aux_register_in, .aux_zero_in, .program_counter, .aux_pointer,
        .aux_register_out, .aux_write, .aux_write_sel, .test_control_flag, .busy, .done, .repeat_refused);
    cbt_mem_model mem_u (.word_sel, .pin_low_req, .data_word, .branch_input_pin_n);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issues one instruction, waits for completion and checks counter and cycle count.
    task automatic run(input logic [15:0] w, input logic [15:0] tgt, input logic tk, input int n);
        @(posedge sys_clk);
        instr_word <= w;
        instr_target <= tgt;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
        cap_aux = aux_register_out;
        cap_ptr = aux_pointer;
        cap_sel = aux_write_sel;
        cap_wr = aux_write;
        cap_tc = test_control_flag;
        cap_n = 1;
        while (done !== 1'b1 && cap_n < 40) begin
            @(negedge sys_clk);
            cap_n++;
        end
        if (w[15:12] == `CBT_OP_BIT || w[15:8] == `CBT_OP_TEST_MEMORY_FLAG_INDEXED) pc_exp = pc_exp + `CBT_PC_STEP_BIT;
        else pc_exp = tk ? tgt : pc_exp + `CBT_PC_STEP_BR;
        @(negedge sys_clk);
        chk(program_counter, pc_exp);
        chk(16'(cap_n), 16'(n));
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        run({`CBT_OP_BR_NONNEG, 7'h00}, 16'h0200, 1'b1, 2);
        sum_register <= 32'hffff_ffff;
        run({`CBT_OP_BR_NONNEG, 7'h00}, 16'h0300, 1'b0, 2);
        run({`CBT_OP_BR_POS, 7'h00}, 16'h0400, 1'b0, 2);
        sum_register <= 32'h0;
        run({`CBT_OP_BR_POS, 7'h00}, 16'h0400, 1'b0, 2);
        sum_register <= 32'h5;
        run({`CBT_OP_BR_POS, 7'h00}, 16'h0500, 1'b1, 2);
        pin_low_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        run({`CBT_OP_BR_PIN, 7'h00}, 16'h0600, 1'b1, 2);
        pin_low_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
        run({`CBT_OP_BR_PIN, 7'h00}, 16'h0680, 1'b0, 2);
        carry_flag <= 1'b1;
        dest_kind <= 2'b01;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h0700, 1'b1, 3);
        dest_kind <= 2'b10;
        prog_wait <= 4'h2;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h0800, 1'b1, 5);
        carry_flag <= 1'b0;
        fetch_external <= 1'b1;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h0900, 1'b0, 6);
        carry_flag <= 1'b1;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h0880, 1'b1, 9);
        dest_kind <= 2'b01;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h08a0, 1'b1, 7);
        dest_kind <= 2'b00;
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h08c0, 1'b1, 6);
        carry_flag <= 1'b0;
        fetch_external <= 1'b0;
        dest_kind <= 2'b00;
        run({`CBT_OP_BR_CARRY, 7'b0101101}, 16'h0a00, 1'b0, 2);
        chk(cap_aux, 16'h1235);
        chk({13'h0, cap_ptr}, 16'h0005);
        run({`CBT_OP_BR_CARRY, 7'h00}, 16'h0b00, 1'b0, 2);
        chk({15'h0, cap_wr}, 16'h0000);
        chk({13'h0, cap_ptr}, 16'h0005);
        chk({13'h0, cap_sel}, 16'h0005);
        carry_flag <= 1'b1;
        run({`CBT_OP_BR_CARRY, 7'b0011000}, 16'h0c00, 1'b1, 2);
        chk(cap_aux, 16'h1233);
        chk({13'h0, cap_ptr}, 16'h0000);
        chk({13'h0, cap_sel}, 16'h0005);
        chk({15'h0, cap_wr}, 16'h0001);
        carry_flag <= 1'b0;
        repeat_active <= 1'b1;
        @(posedge sys_clk);
        instr_word <= {`CBT_OP_BR_POS, 7'h00};
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0, repeat_refused}, 16'h0001);
        @(negedge sys_clk);
        chk(program_counter, pc_exp);
        @(posedge sys_clk);
        repeat_active <= 1'b0;
        for (i = 0; i < 16; i++) begin
            run({`CBT_OP_BIT, 4'(i), 8'h00}, 16'h0000, 1'b0, 1);
            chk({15'h0, cap_tc}, {15'h0, PAT0[15 - i]});
        end
        word_sel <= 1'b1;
        for (i = 0; i < 16; i += 5) begin
            mult_operand <= {12'habc, 4'(i)};
            run({`CBT_OP_TEST_MEMORY_FLAG_INDEXED, 8'h00}, 16'h0000, 1'b0, 1);
            chk({15'h0, cap_tc}, {15'h0, PAT1[15 - i]});
        end
        data_external <= 1'b1;
        data_wait <= 4'h3;
        run({`CBT_OP_TEST_MEMORY_FLAG_INDEXED, 8'h00}, 16'h0000, 1'b0, 5);
        fetch_external <= 1'b1;
        run({`CBT_OP_TEST_MEMORY_FLAG_INDEXED, 8'h00}, 16'h0000, 1'b0, 7);
        conclude();
    end
endmodule
